// ### rtl/port_pin_mode_control.sv
// pin function control of the four general purpose ports
`timescale 1ns/10ps
`include "pin_mode_map.svh"

module port_pin_mode_control #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire pin_mode_pkg::byte_t REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire logic [15:0] AD_IN,
  input wire logic ALE_IN,
  input wire logic RD_N_IN,
  input wire logic WR_N_IN,
  output pin_mode_pkg::byte_t BUS_DATA_OUT,
  output logic BUS_DATA_OE_OUT,
  input wire logic REPEATER_MODE_ON_IN,
  input wire logic PERIPH_SELECT_0_IN,
  input wire logic PERIPH_SELECT_1_IN,
  input wire pin_mode_pkg::byte_t PORT_B_HIGH_BYTE_IN,
  input wire logic PROG_PINS_EN_IN,
  input wire logic PROG_STATUS_IN,
  input wire logic PROG_ERROR_IN,
  input wire pin_mode_pkg::byte_t ARRAY_PIN_A_IN,
  input wire pin_mode_pkg::byte_t ARRAY_PIN_B_IN,
  input wire pin_mode_pkg::byte_t ARRAY_PIN_C_IN,
  input wire pin_mode_pkg::byte_t ARRAY_PIN_D_IN,
  input wire pin_mode_pkg::byte_t ARRAY_DATA_A_IN,
  input wire pin_mode_pkg::byte_t ARRAY_DATA_B_IN,
  input wire pin_mode_pkg::byte_t ARRAY_DATA_C_IN,
  input wire pin_mode_pkg::byte_t ARRAY_DATA_D_IN,
  input wire pin_mode_pkg::byte_t ARRAY_OE_A_IN,
  input wire pin_mode_pkg::byte_t ARRAY_OE_B_IN,
  input wire pin_mode_pkg::byte_t ARRAY_OE_C_IN,
  input wire pin_mode_pkg::byte_t ARRAY_OE_D_IN,
  output pin_mode_pkg::byte_t ARRAY_IN_A_OUT,
  output pin_mode_pkg::byte_t ARRAY_IN_B_OUT,
  output pin_mode_pkg::byte_t ARRAY_IN_C_OUT,
  output pin_mode_pkg::byte_t ARRAY_IN_D_OUT,
  input wire pin_mode_pkg::byte_t PIN_A_IN,
  input wire pin_mode_pkg::byte_t PIN_B_IN,
  input wire pin_mode_pkg::byte_t PIN_C_IN,
  input wire pin_mode_pkg::byte_t PIN_D_IN,
  output pin_mode_pkg::byte_t PIN_A_OUT,
  output pin_mode_pkg::byte_t PIN_B_OUT,
  output pin_mode_pkg::byte_t PIN_C_OUT,
  output pin_mode_pkg::byte_t PIN_D_OUT,
  output pin_mode_pkg::byte_t PIN_A_OE_OUT,
  output pin_mode_pkg::byte_t PIN_B_OE_OUT,
  output pin_mode_pkg::byte_t PIN_C_OE_OUT,
  output pin_mode_pkg::byte_t PIN_D_OE_OUT,
  output pin_mode_pkg::byte_t DRIVE_A_OUT,
  output pin_mode_pkg::byte_t DRIVE_B_OUT,
  output pin_mode_pkg::byte_t DRIVE_C_OUT,
  output pin_mode_pkg::byte_t DRIVE_D_OUT
);
  import pin_mode_pkg::*;

  // ------------------------------------------------------------
  // implemented pins and gathered inputs
  // ------------------------------------------------------------
  localparam byte_t MASK_D = SMALL_PACKAGE ? `MASK_D_SMALL : `MASK_D_LARGE;
  localparam port_set_t IMPL = {MASK_D, `MASK_C, `MASK_B, `MASK_A};

  // ------------------------------------------------------------
  // state and helper signals
  // ------------------------------------------------------------
  state_s s;
  state_s n;
  port_set_t arr_sel;
  port_set_t arr_d;
  port_set_t arr_oe;
  port_set_t pin_in;
  port_set_t pin_o_w;
  port_set_t pin_oe_w;
  logic rep_mode;
  logic rep_hit;
  logic rep_wr;
  logic rep_rd;

  assign arr_sel = {ARRAY_PIN_D_IN, ARRAY_PIN_C_IN, ARRAY_PIN_B_IN, ARRAY_PIN_A_IN};
  assign arr_d = {ARRAY_DATA_D_IN, ARRAY_DATA_C_IN, ARRAY_DATA_B_IN, ARRAY_DATA_A_IN};
  assign arr_oe = {ARRAY_OE_D_IN, ARRAY_OE_C_IN, ARRAY_OE_B_IN, ARRAY_OE_A_IN};
  assign pin_in = {PIN_D_IN, PIN_C_IN, PIN_B_IN, PIN_A_IN};

  // ------------------------------------------------------------
  // repeater decode
  // ------------------------------------------------------------
  // selects already carry page and program strobe qualification
  assign rep_mode = REPEATER_MODE_ON_IN;
  assign rep_hit = rep_mode & (PERIPH_SELECT_0_IN | PERIPH_SELECT_1_IN);
  assign rep_wr = rep_hit & ~WR_N_IN;
  assign rep_rd = rep_hit & ~RD_N_IN & WR_N_IN;

  // ------------------------------------------------------------
  // per-pin function mux
  // ------------------------------------------------------------
  // priority: absent, repeater, prog pins, array, address, data-out
  for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port
    for (genvar b = 0; b < `PORT_WIDTH; b++) begin : g_bit
      logic addr_sel;
      logic addr_bit;
      logic prog_pin;
      logic prog_val;
      if (p == `PORT_A) begin : g_a
        assign addr_sel = s.ctl_a[b];
        assign addr_bit = s.addr[b];
      end else if (p == `PORT_B) begin : g_b
        assign addr_sel = s.ctl_b[b];
        assign addr_bit = PORT_B_HIGH_BYTE_IN[b] ? s.addr[b + `HIGH_BYTE_OFS] : s.addr[b];
      end else begin : g_cd
        assign addr_sel = 1'b0;
        assign addr_bit = 1'b0;
      end
      if (p == `PORT_C && (b == `BIT_STATUS || b == `BIT_ERROR)) begin : g_prog
        assign prog_pin = PROG_PINS_EN_IN;
        assign prog_val = (b == `BIT_STATUS) ? PROG_STATUS_IN : PROG_ERROR_IN;
      end else begin : g_noprog
        assign prog_pin = 1'b0;
        assign prog_val = 1'b0;
      end
      always_comb begin
        if (!IMPL[p][b]) begin
          // test port and absent pins never driven here
          pin_o_w[p][b] = 1'b0;
          pin_oe_w[p][b] = 1'b0;
        end else if (p == `PORT_A && rep_mode) begin
          pin_o_w[p][b] = AD_IN[b];
          pin_oe_w[p][b] = rep_wr;
        end else if (prog_pin) begin
          pin_o_w[p][b] = prog_val;
          pin_oe_w[p][b] = 1'b1;
        end else if (arr_sel[p][b]) begin
          // internal-node macrocells leave arr_sel low
          pin_o_w[p][b] = arr_d[p][b];
          pin_oe_w[p][b] = arr_oe[p][b] | s.dir[p][b];
        end else if (addr_sel) begin
          pin_o_w[p][b] = addr_bit;
          pin_oe_w[p][b] = 1'b1;
        end else begin
          pin_o_w[p][b] = s.dout[p][b];
          pin_oe_w[p][b] = arr_oe[p][b] | s.dir[p][b];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    n = s;

    // ----------------------------------------------------------
    // pin input synchroniser
    // ----------------------------------------------------------
    // value moves once second and third agree
    n.s1 = pin_in;
    n.s2 = s.s1;
    n.s3 = s.s2;
    for (int p = 0; p < `NUM_PORTS; p++) begin
      for (int b = 0; b < `PORT_WIDTH; b++) begin
        if (s.s2[p][b] == s.s3[p][b]) begin
          n.pv[p][b] = s.s3[p][b];
        end
      end
    end

    // ----------------------------------------------------------
    // logic input bus
    // ----------------------------------------------------------
    n.input_macrocell = s.pv;
    n.input_macrocell[`PORT_D] = `REG_RESET;
    n.arr_in = s.input_macrocell;
    n.arr_in[`PORT_D] = s.pv[`PORT_D];

    // ----------------------------------------------------------
    // address latch and pin outputs
    // ----------------------------------------------------------
    if (ALE_IN) begin
      n.addr = AD_IN;
    end
    n.pin_o = pin_o_w;
    n.pin_oe = pin_oe_w;
    n.bus_d = s.pv[`PORT_A];
    n.bus_oe = rep_rd;

    // ----------------------------------------------------------
    // register writes
    // ----------------------------------------------------------
    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        `OFS_CTL_A: n.ctl_a = REG_WDATA_IN;
        `OFS_CTL_B: n.ctl_b = REG_WDATA_IN;
        `OFS_DOUT_A: n.dout[`PORT_A] = REG_WDATA_IN & IMPL[`PORT_A];
        `OFS_DOUT_B: n.dout[`PORT_B] = REG_WDATA_IN & IMPL[`PORT_B];
        `OFS_DOUT_C: n.dout[`PORT_C] = REG_WDATA_IN & IMPL[`PORT_C];
        `OFS_DOUT_D: n.dout[`PORT_D] = REG_WDATA_IN & IMPL[`PORT_D];
        `OFS_DIR_A: n.dir[`PORT_A] = REG_WDATA_IN & IMPL[`PORT_A];
        `OFS_DIR_B: n.dir[`PORT_B] = REG_WDATA_IN & IMPL[`PORT_B];
        `OFS_DIR_C: n.dir[`PORT_C] = REG_WDATA_IN & IMPL[`PORT_C];
        `OFS_DIR_D: n.dir[`PORT_D] = REG_WDATA_IN & IMPL[`PORT_D];
        `OFS_DRV_A: n.drv[`PORT_A] = REG_WDATA_IN & IMPL[`PORT_A];
        `OFS_DRV_B: n.drv[`PORT_B] = REG_WDATA_IN & IMPL[`PORT_B];
        `OFS_DRV_C: n.drv[`PORT_C] = REG_WDATA_IN & IMPL[`PORT_C];
        `OFS_DRV_D: n.drv[`PORT_D] = REG_WDATA_IN & IMPL[`PORT_D];
        default: n.rdata = s.rdata;
      endcase
    end

    // ----------------------------------------------------------
    // register reads
    // ----------------------------------------------------------
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `OFS_DIN_A: n.rdata = s.pv[`PORT_A];
        `OFS_DIN_B: n.rdata = s.pv[`PORT_B];
        `OFS_DIN_C: n.rdata = s.pv[`PORT_C] & IMPL[`PORT_C];
        `OFS_DIN_D: n.rdata = s.pv[`PORT_D] & IMPL[`PORT_D];
        `OFS_CTL_A: n.rdata = s.ctl_a;
        `OFS_CTL_B: n.rdata = s.ctl_b;
        `OFS_DOUT_A: n.rdata = s.dout[`PORT_A];
        `OFS_DOUT_B: n.rdata = s.dout[`PORT_B];
        `OFS_DOUT_C: n.rdata = s.dout[`PORT_C];
        `OFS_DOUT_D: n.rdata = s.dout[`PORT_D];
        `OFS_DIR_A: n.rdata = s.dir[`PORT_A];
        `OFS_DIR_B: n.rdata = s.dir[`PORT_B];
        `OFS_DIR_C: n.rdata = s.dir[`PORT_C];
        `OFS_DIR_D: n.rdata = s.dir[`PORT_D];
        `OFS_DRV_A: n.rdata = s.drv[`PORT_A];
        `OFS_DRV_B: n.rdata = s.drv[`PORT_B];
        `OFS_DRV_C: n.rdata = s.drv[`PORT_C];
        `OFS_DRV_D: n.rdata = s.drv[`PORT_D];
        `OFS_OE_A: n.rdata = s.pin_oe[`PORT_A];
        `OFS_OE_B: n.rdata = s.pin_oe[`PORT_B];
        `OFS_OE_C: n.rdata = s.pin_oe[`PORT_C];
        `OFS_OE_D: n.rdata = s.pin_oe[`PORT_D];
        default: n.rdata = `REG_RESET;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign REG_RDATA_OUT = s.rdata;
  assign BUS_DATA_OUT = s.bus_d;
  assign BUS_DATA_OE_OUT = s.bus_oe;
  assign ARRAY_IN_A_OUT = s.arr_in[`PORT_A];
  assign ARRAY_IN_B_OUT = s.arr_in[`PORT_B];
  assign ARRAY_IN_C_OUT = s.arr_in[`PORT_C];
  assign ARRAY_IN_D_OUT = s.arr_in[`PORT_D];
  assign PIN_A_OUT = s.pin_o[`PORT_A];
  assign PIN_B_OUT = s.pin_o[`PORT_B];
  assign PIN_C_OUT = s.pin_o[`PORT_C];
  assign PIN_D_OUT = s.pin_o[`PORT_D];
  assign PIN_A_OE_OUT = s.pin_oe[`PORT_A];
  assign PIN_B_OE_OUT = s.pin_oe[`PORT_B];
  assign PIN_C_OE_OUT = s.pin_oe[`PORT_C];
  assign PIN_D_OE_OUT = s.pin_oe[`PORT_D];
  assign DRIVE_A_OUT = s.drv[`PORT_A];
  assign DRIVE_B_OUT = s.drv[`PORT_B];
  assign DRIVE_C_OUT = s.drv[`PORT_C];
  assign DRIVE_D_OUT = s.drv[`PORT_D];
endmodule

// ### rtl/pin_mode_map.svh
// register offsets, masks and reset values of the port pin mode block
`ifndef PIN_MODE_MAP_SVH
`define PIN_MODE_MAP_SVH
`define OFS_DIN_A 8'h00
`define OFS_DIN_B 8'h01
`define OFS_DIN_C 8'h10
`define OFS_DIN_D 8'h11
`define OFS_CTL_A 8'h02
`define OFS_CTL_B 8'h03
`define OFS_DOUT_A 8'h04
`define OFS_DOUT_B 8'h05
`define OFS_DOUT_C 8'h12
`define OFS_DOUT_D 8'h13
`define OFS_DIR_A 8'h06
`define OFS_DIR_B 8'h07
`define OFS_DIR_C 8'h14
`define OFS_DIR_D 8'h15
`define OFS_DRV_A 8'h08
`define OFS_DRV_B 8'h09
`define OFS_DRV_C 8'h16
`define OFS_DRV_D 8'h17
`define OFS_OE_A 8'h0c
`define OFS_OE_B 8'h0d
`define OFS_OE_C 8'h1a
`define OFS_OE_D 8'h1b
`define MASK_A 8'hff
`define MASK_B 8'hff
`define MASK_C 8'h9c
`define MASK_D_LARGE 8'h06
`define MASK_D_SMALL 8'h02
`define REG_RESET 8'h00
`define BIT_STATUS 3
`define BIT_ERROR 4
`define PORT_A 0
`define PORT_B 1
`define PORT_C 2
`define PORT_D 3
`define NUM_PORTS 4
`define PORT_WIDTH 8
`define HIGH_BYTE_OFS 8
`endif

// ### rtl/pin_mode_pkg.sv
// types of the port pin mode block
package pin_mode_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0][7:0] port_set_t;
  typedef struct packed {
    port_set_t dout;
    port_set_t dir;
    port_set_t drv;
    port_set_t s1;
    port_set_t s2;
    port_set_t s3;
    port_set_t pv;
    port_set_t input_macrocell;
    port_set_t pin_o;
    port_set_t pin_oe;
    port_set_t arr_in;
    byte_t ctl_a;
    byte_t ctl_b;
    logic [15:0] addr;
    byte_t rdata;
    byte_t bus_d;
    logic bus_oe;
  } state_s;
endpackage

// ### verif/port_pin_mode_control_properties.sv
// port level checks of the port pin mode block
`timescale 1ns/10ps
module port_pin_mode_properties (
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [15:0] AD_IN,
  input wire logic RD_N_IN,
  input wire logic WR_N_IN,
  input wire logic REPEATER_MODE_ON_IN,
  input wire logic PERIPH_SELECT_0_IN,
  input wire logic PERIPH_SELECT_1_IN,
  input wire logic PROG_PINS_EN_IN,
  input wire logic PROG_STATUS_IN,
  input wire logic PROG_ERROR_IN,
  input wire pin_mode_pkg::byte_t ARRAY_PIN_B_IN,
  input wire pin_mode_pkg::byte_t ARRAY_DATA_B_IN,
  input wire pin_mode_pkg::byte_t ARRAY_OE_B_IN,
  input wire pin_mode_pkg::byte_t PIN_A_OUT,
  input wire pin_mode_pkg::byte_t PIN_A_OE_OUT,
  input wire pin_mode_pkg::byte_t PIN_B_OUT,
  input wire pin_mode_pkg::byte_t PIN_B_OE_OUT,
  input wire pin_mode_pkg::byte_t PIN_C_OUT,
  input wire pin_mode_pkg::byte_t PIN_C_OE_OUT,
  input wire pin_mode_pkg::byte_t PIN_D_OE_OUT,
  input wire logic BUS_DATA_OE_OUT
);
  import pin_mode_pkg::*;
  logic rep_sel;
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  assign rep_sel = REPEATER_MODE_ON_IN && (PERIPH_SELECT_0_IN || PERIPH_SELECT_1_IN);
  a_oe_term_dir: assert property (
    (ARRAY_OE_B_IN != 8'h00) |=> ((PIN_B_OE_OUT & $past(ARRAY_OE_B_IN)) == $past(ARRAY_OE_B_IN)))
    else $error("port b enable misses array term");
  a_array_data_out: assert property (
    (ARRAY_PIN_B_IN != 8'h00) |=> (((PIN_B_OUT ^ $past(ARRAY_DATA_B_IN)) & $past(ARRAY_PIN_B_IN)) == 8'h00))
    else $error("array output pin not from array");
  a_rep_write: assert property (
    rep_sel && !WR_N_IN |=> PIN_A_OE_OUT == 8'hff && {8'h00, PIN_A_OUT} == ($past(AD_IN) & 16'h00ff))
    else $error("repeater write not driven");
  a_rep_read: assert property (
    rep_sel && !RD_N_IN && WR_N_IN |=> PIN_A_OE_OUT == 8'h00 && BUS_DATA_OE_OUT)
    else $error("repeater read not turned round");
  a_rep_port_held: assert property (
    REPEATER_MODE_ON_IN && !(rep_sel && !WR_N_IN) |=> PIN_A_OE_OUT == 8'h00)
    else $error("port a driven outside repeater write");
  a_test_pins_off: assert property (
    (PIN_C_OE_OUT & 8'h63) == 8'h00) else $error("test port pin driven");
  a_dir_d_bits: assert property (
    (PIN_D_OE_OUT & 8'hf9) == 8'h00) else $error("absent port d pin driven");
  a_prog_pins_out: assert property (
    PROG_PINS_EN_IN |=> PIN_C_OE_OUT[4:3] == 2'b11 && PIN_C_OUT[3] == $past(PROG_STATUS_IN)
      && PIN_C_OUT[4] == $past(PROG_ERROR_IN)) else $error("programming pins wrong");
endmodule
bind port_pin_mode_control port_pin_mode_properties u_props (.REF_CLK_IN, .RST_B_IN, .AD_IN, .RD_N_IN,
  .WR_N_IN, .REPEATER_MODE_ON_IN, .PERIPH_SELECT_0_IN, .PERIPH_SELECT_1_IN, .PROG_PINS_EN_IN, .PROG_STATUS_IN,
  .PROG_ERROR_IN, .ARRAY_PIN_B_IN, .ARRAY_DATA_B_IN, .ARRAY_OE_B_IN, .PIN_A_OUT, .PIN_A_OE_OUT, .PIN_B_OUT,
  .PIN_B_OE_OUT, .PIN_C_OUT, .PIN_C_OE_OUT, .PIN_D_OE_OUT, .BUS_DATA_OE_OUT);

// ### verif/port_pins_partner.sv
// pad model: each pin shows the block's drive or the outside level
`timescale 1ns/10ps
module port_pins_partner (
  input wire pin_mode_pkg::port_set_t drive_val_in,
  input wire pin_mode_pkg::port_set_t drive_en_in,
  input wire pin_mode_pkg::port_set_t outside_in,
  output pin_mode_pkg::port_set_t pin_out
);
  // released pins take the outside level, pulled high unless a peripheral drives
  assign pin_out = (drive_en_in & drive_val_in) | (~drive_en_in & outside_in);
endmodule

// ### verif/port_pin_mode_control_bench.sv
// self-checking bench of the port pin mode block
`timescale 1ns/10ps
`include "pin_mode_map.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end
module port_pin_mode_control_bench;
  import pin_mode_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, ale = 1'b0, rd_n = 1'b1, wr_n = 1'b1;
  logic mode_on = 1'b0, prog_en = 1'b0, stat = 1'b0, err = 1'b0;
  logic [1:0] sel = 2'b00;
  logic [7:0] addr = 8'h00;
  logic [15:0] ad = 16'h0000;
  byte_t wdata = 8'h00, hb = 8'h00;
  port_set_t apin = '0, adata = '0, aoe = '0, ext = '1;
  port_set_t msk = {8'h06, 8'h9c, 8'hff, 8'hff};
  wire byte_t rdata, bus_d;
  wire logic bus_oe;
  wire port_set_t ain, pout, poe, drv, pin;
  logic [7:0] zero_regs [11] = '{8'h02, 8'h03, 8'h15, 8'h0c, 8'h0d, 8'h1a, 8'h1b, 8'h08, 8'h09, 8'h16, 8'h17};
  int errors = 0;
  int tests_run = 0;
  always #10 ref_clk = ~ref_clk;
  port_pin_mode_control u_dut (.REF_CLK_IN(ref_clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .AD_IN(ad), .ALE_IN(ale), .RD_N_IN(rd_n),
    .WR_N_IN(wr_n), .BUS_DATA_OUT(bus_d), .BUS_DATA_OE_OUT(bus_oe), .REPEATER_MODE_ON_IN(mode_on),
    .PERIPH_SELECT_0_IN(sel[0]), .PERIPH_SELECT_1_IN(sel[1]), .PORT_B_HIGH_BYTE_IN(hb), .PROG_PINS_EN_IN(prog_en),
    .PROG_STATUS_IN(stat), .PROG_ERROR_IN(err), .ARRAY_PIN_A_IN(apin[0]), .ARRAY_PIN_B_IN(apin[1]),
    .ARRAY_PIN_C_IN(apin[2]), .ARRAY_PIN_D_IN(apin[3]), .ARRAY_DATA_A_IN(adata[0]), .ARRAY_DATA_B_IN(adata[1]),
    .ARRAY_DATA_C_IN(adata[2]), .ARRAY_DATA_D_IN(adata[3]), .ARRAY_OE_A_IN(aoe[0]), .ARRAY_OE_B_IN(aoe[1]),
    .ARRAY_OE_C_IN(aoe[2]), .ARRAY_OE_D_IN(aoe[3]), .ARRAY_IN_A_OUT(ain[0]), .ARRAY_IN_B_OUT(ain[1]),
    .ARRAY_IN_C_OUT(ain[2]), .ARRAY_IN_D_OUT(ain[3]), .PIN_A_IN(pin[0]), .PIN_B_IN(pin[1]), .PIN_C_IN(pin[2]),
    .PIN_D_IN(pin[3]), .PIN_A_OUT(pout[0]), .PIN_B_OUT(pout[1]), .PIN_C_OUT(pout[2]), .PIN_D_OUT(pout[3]),
    .PIN_A_OE_OUT(poe[0]), .PIN_B_OE_OUT(poe[1]), .PIN_C_OE_OUT(poe[2]), .PIN_D_OE_OUT(poe[3]),
    .DRIVE_A_OUT(drv[0]), .DRIVE_B_OUT(drv[1]), .DRIVE_C_OUT(drv[2]), .DRIVE_D_OUT(drv[3]));
  port_pins_partner u_pins (.drive_val_in(pout), .drive_en_in(poe), .outside_in(ext), .pin_out(pin));
  // ----------------------------------------
  // register access and closing
  // ----------------------------------------
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input byte_t v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic reg_chk(input logic [7:0] a, input byte_t exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, exp)
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (zero_regs[i]) reg_chk(zero_regs[i], 8'h00);
    reg_wr(8'h40, 8'hff);
    reg_chk(8'h40, 8'h00);
    $display("test reset values done");
    reg_wr(`OFS_DIR_D, 8'hff);
    reg_chk(`OFS_DIR_D, 8'h06);
    reg_chk(`OFS_OE_D, 8'h06);
    reg_wr(`OFS_DIR_D, 8'h00);
    aoe[3] <= 8'h02;
    reg_chk(`OFS_OE_D, 8'h02);
    @(posedge ref_clk);
    aoe[3] <= 8'h00;
    reg_wr(`OFS_DRV_A, 8'h5a);
    reg_wr(`OFS_DRV_B, 8'ha5);
    reg_wr(`OFS_DRV_C, 8'hff);
    reg_wr(`OFS_DRV_D, 8'hff);
    reg_chk(`OFS_DRV_D, 8'h06);
    `CHK(drv, {8'h06, 8'h9c, 8'ha5, 8'h5a})
    $display("test direction and enables done");
    reg_wr(`OFS_CTL_A, 8'h0f);
    reg_wr(`OFS_CTL_B, 8'hff);
    reg_chk(`OFS_CTL_A, 8'h0f);
    @(posedge ref_clk);
    ad <= 16'h5aa5;
    ale <= 1'b1;
    hb <= 8'hf0;
    @(posedge ref_clk);
    ale <= 1'b0;
    ad <= 16'h0000;
    settle(3);
    `CHK(pout[0] & 8'h0f, 8'h05)
    `CHK(poe[0], 8'h0f)
    `CHK(pout[1], (hb & 8'h5a) | (~hb & 8'ha5))
    reg_wr(`OFS_CTL_A, 8'h00);
    reg_wr(`OFS_CTL_B, 8'h00);
    $display("test address out done");
    reg_wr(`OFS_DOUT_B, 8'hff);
    reg_wr(`OFS_DIR_B, 8'hff);
    apin <= '1;
    aoe <= '1;
    adata <= 32'h3c5a_a569;
    settle(2);
    for (int p = 0; p < 4; p++) begin
      `CHK(pout[p], adata[p] & msk[p])
      `CHK(poe[p], msk[p])
    end
    @(posedge ref_clk);
    apin <= '0;
    aoe <= '0;
    settle(2);
    `CHK(pout[1], 8'hff)
    $display("test array outputs done");
    reg_wr(`OFS_DIR_B, 8'h0f);
    ext <= 32'h90c3_a55a;
    settle(7);
    `CHK(ain[0], ext[0])
    `CHK(ain[1], {ext[1][7:4], 4'hf})
    `CHK(ain[2] & msk[2], ext[2] & msk[2])
    `CHK(ain[3] & 8'h06, ext[3] & 8'h06)
    reg_chk(`OFS_DIN_B, {ext[1][7:4], 4'hf});
    $display("test pin inputs done");
    reg_wr(`OFS_DIR_A, 8'hff);
    mode_on <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk);
      sel <= 2'b01 << s;
      wr_n <= 1'b0;
      ad <= {8'h00, 8'h3c ^ 8'(s)};
      settle(1);
      `CHK(poe[0], 8'hff)
      `CHK(pout[0], 8'h3c ^ 8'(s))
      @(posedge ref_clk);
      wr_n <= 1'b1;
      rd_n <= 1'b0;
      ext[0] <= 8'hc3 ^ 8'(s);
      settle(6);
      `CHK(poe[0], 8'h00)
      `CHK(bus_oe, 1'b1)
      `CHK(bus_d, 8'hc3 ^ 8'(s))
      @(posedge ref_clk);
      rd_n <= 1'b1;
      sel <= 2'b00;
    end
    settle(2);
    `CHK(poe[0], 8'h00)
    @(posedge ref_clk);
    mode_on <= 1'b0;
    settle(2);
    `CHK(poe[0], 8'hff)
    $display("test repeater done");
    reg_wr(`OFS_DIR_C, 8'hff);
    reg_chk(`OFS_DIR_C, 8'h9c);
    @(posedge ref_clk);
    prog_en <= 1'b1;
    stat <= 1'b1;
    settle(2);
    `CHK(poe[2], 8'h9c)
    `CHK(pout[2] & 8'h18, 8'h08)
    $display("test programming pins done");
    summarize();
  end
endmodule
